// >>> dv/rmi_gpr_model.sv
// Purpose: Register file model standing behind the unit's operand ports
// Assumes: Operands are looked up from the index fields of the issued word
// Notes:   Operands show inverted values outside an issue cycle
`timescale 1ns/100ps

module rmi_gpr_model (
  input  wire logic        core_clk,     // Core clock
  input  wire logic        issueValid,   // Issue strobe from the bench
  input  wire logic [31:0] instrWord,    // Word carrying the index fields
  input  wire logic        resultValid,  // Write-back pulse from the unit
  input  wire logic [4:0]  resultIdx,    // Write-back index
  input  wire logic [31:0] resultData,   // Write-back value
  input  wire logic        loadEn,       // Bench preload strobe
  input  wire logic [4:0]  loadIdx,      // Preload index
  input  wire logic [31:0] loadVal,      // Preload value
  output logic [31:0]      sourceVal,    // source_reg contents
  output logic [31:0]      shiftVal,     // shift_amount_reg contents
  output logic [31:0]      destVal       // dest_reg contents
);
  logic [31:0] gpr [32];  // Register storage

  // ==========================================================
  // Write port
  // ==========================================================
  // Write-back wins; the bench never preloads while results are due
  always_ff @(posedge core_clk) begin
    if (resultValid) begin
      gpr[resultIdx] <= resultData;
    end else if (loadEn) begin
      gpr[loadIdx] <= loadVal;
    end
  end

  // ==========================================================
  // Read ports
  // ==========================================================
  // Inverted outside issue so a unit sampling late sees wrong data
  assign sourceVal = issueValid ? gpr[instrWord[25:21]] : ~gpr[instrWord[25:21]];
  assign destVal   = issueValid ? gpr[instrWord[20:16]] : ~gpr[instrWord[20:16]];
  assign shiftVal  = issueValid ? gpr[instrWord[15:11]] : ~gpr[instrWord[15:11]];
endmodule : rmi_gpr_model

// >>> dv/test_rotate_mask_insert_unit.sv
// Purpose: Self-checking bench for the rotate, mask and insert unit
// Assumes: One result cycle after issue, registers read one cycle later
// Notes:   Expected values come from a shadow copy of the register file
`timescale 1ns/100ps

module test_rotate_mask_insert_unit;
  logic        core_clk, nrst, issueValid, xerSumOvf, regWr, regRd, loadEn;
  logic [31:0] instrWord, sourceVal, shiftVal, destVal, regWrData, regRdData, resultData, loadVal;
  logic [3:0]  regAddr, crField;
  logic [4:0]  resultIdx, loadIdx;
  logic        resultValid, crWrEn, illegalOp;
  logic [31:0] gprShadow [32];  // Bench copy of the register file
  logic        legacy;          // Expected legacy mode bit
  logic [3:0]  crExp;           // Expected condition field
  logic [31:0] lastRes;         // Expected last result
  int          fails, nTests, doneCnt, refCnt;
  int          begT [8] = '{0, 5, 31, 0, 31, 10, 16, 30};  // Mask corners
  int          endT [8] = '{31, 4, 0, 0, 31, 3, 15, 29};

  rmi_rotate_mask_insert_unit rmi_rotate_mask_insert_unit_inst (.core_clk(core_clk), .nrst(nrst),
    .issueValid(issueValid), .instrWord(instrWord), .sourceVal(sourceVal), .shiftVal(shiftVal),
    .destVal(destVal), .xerSumOvf(xerSumOvf), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .resultValid(resultValid), .resultIdx(resultIdx),
    .resultData(resultData), .crWrEn(crWrEn), .crField(crField), .illegalOp(illegalOp));
  rmi_gpr_model rmi_gpr_model_inst (.core_clk(core_clk), .issueValid(issueValid), .instrWord(instrWord),
    .resultValid(resultValid), .resultIdx(resultIdx), .resultData(resultData), .loadEn(loadEn),
    .loadIdx(loadIdx), .loadVal(loadVal), .sourceVal(sourceVal), .shiftVal(shiftVal), .destVal(destVal));

  // ==========================================================
  // Clock and watchdog
  // ==========================================================
  always #20 core_clk = ~core_clk;
  // Hang guard, far above the real run length
  initial begin
    repeat (100000) @(posedge core_clk);
    fails++;
    report_and_stop();
  end

  // ==========================================================
  // Checking and prediction
  // ==========================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", nTests, fails);
    if (fails == 0 && nTests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  function automatic logic [31:0] mk(logic [5:0] o, logic [4:0] s, logic [4:0] d, logic [4:0] b,
                                     logic [9:0] x, logic rec);
    return {o, s, d, b, x, rec};
  endfunction : mk

  // Position p counts from the most significant bit
  function automatic logic [31:0] calc(input logic [31:0] iw);
    logic [31:0] s, d, m;
    int          n, bg, en;
    s = gprShadow[iw[25:21]];
    d = gprShadow[iw[20:16]];
    n = gprShadow[iw[15:11]][4:0];
    bg = iw[10:6];
    en = iw[5:1];
    if (iw[31:26] != rmi_pkg::OPC_ROT_MASK) begin
      d[31-n] = s[31];
      return d;
    end
    for (int p = 0; p < 32; p++) m[31-p] = (bg <= en) ? (p >= bg && p <= en) : (p <= en || p >= bg);
    return ((s << n) | (s >> (32 - n))) & m;
  endfunction : calc

  task automatic chk_res(input logic [31:0] iw, input logic [31:0] r, input logic sv);
    logic ins, ok;
    ins = iw[31:26] == rmi_pkg::OPC_EXTENDED && iw[10:1] == rmi_pkg::XO_ROT_INS;
    ok = iw[31:26] == rmi_pkg::OPC_ROT_MASK || (ins && legacy);
    check(resultValid, ok);
    check(illegalOp, ins && !legacy);
    check(crWrEn, ok && iw[0]);
    if (ok) begin
      check(resultIdx, iw[20:16]);
      check(resultData, r);
      if (iw[0]) crExp = {r[31], !r[31] && r != 0, r == 0, sv};
      gprShadow[iw[20:16]] = r;
      lastRes = r;
      doneCnt++;
    end
    if (ins && !legacy) refCnt++;
    check(crField, crExp);
  endtask : chk_res

  // ==========================================================
  // Port tasks
  // ==========================================================
  // Issue one word, or two back to back; both predicted before either lands
  task automatic run(input logic [31:0] a, input logic [31:0] b, input bit two);
    logic [31:0] resA, resB;
    logic        sv;
    resA = calc(a);
    resB = calc(b);
    sv = $urandom;
    @(posedge core_clk);
    issueValid <= 1'b1;
    instrWord  <= a;
    xerSumOvf  <= sv;
    @(posedge core_clk);
    if (two) instrWord <= b;
    else issueValid <= 1'b0;
    @(negedge core_clk);
    chk_res(a, resA, sv);
    if (two) begin
      @(posedge core_clk);
      issueValid <= 1'b0;
      @(negedge core_clk);
      chk_res(b, resB, sv);
    end
  endtask : run

  task automatic ld(input logic [4:0] i, input logic [31:0] v);
    @(posedge core_clk);
    loadEn  <= 1'b1;
    loadIdx <= i;
    loadVal <= v;
    gprShadow[i] = v;
    @(posedge core_clk);
    loadEn <= 1'b0;
  endtask : ld

  task automatic rw(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regWr     <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask : rw

  task automatic rr(input logic [3:0] a, input logic [31:0] e);
    @(posedge core_clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    @(negedge core_clk);
    check(regRdData, e);
  endtask : rr

  // Random mix: rotate-and-mask at double weight, insert, and an excluded opcode
  task automatic burst(input int n);
    logic [31:0] w [2];
    int          k;
    for (int i = 0; i < n; i++) begin
      for (int j = 0; j < 2; j++) begin
        k = $urandom % 4;
        w[j] = mk(k == 2 ? rmi_pkg::OPC_EXTENDED : k == 3 ? 6'h15 : rmi_pkg::OPC_ROT_MASK,
                  5'($urandom), 5'($urandom), 5'($urandom), k == 2 ? rmi_pkg::XO_ROT_INS : 10'($urandom), 1'($urandom));
      end
      run(w[0], w[1], 1'($urandom));
    end
  endtask : burst

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    core_clk = 0; nrst = 0; issueValid = 0; instrWord = 0; xerSumOvf = 0; regAddr = 0; regWrData = 0;
    regWr = 0; regRd = 0; loadEn = 0; loadIdx = 0; loadVal = 0;
    fails = 0; nTests = 0; doneCnt = 0; refCnt = 0; legacy = 1; crExp = 0; lastRes = 0;
    void'($urandom(92));
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    @(negedge core_clk);
    check(crField, 4'h0);
    rr(rmi_pkg::REG_CTRL, 32'h1);
    rr(4'hc, 32'h0);
    for (int i = 0; i < 32; i++) ld(i, $urandom);
    ld(3, 32'hffffffe0);  // Count zero with high bits set
    ld(4, 32'h0000001f);
    for (int i = 0; i < 16; i++) run(mk(rmi_pkg::OPC_ROT_MASK, 5'($urandom), 5'd9, 5'(3 + i % 2),
      {5'(begT[i%8]), 5'(endT[i%8])}, 1'(i / 8)), 32'h0, 1'b0);
    for (int i = 0; i < 2; i++) run(mk(rmi_pkg::OPC_EXTENDED, 5'd1, 5'd2, 5'(3 + i), rmi_pkg::XO_ROT_INS,
      1'(i)), 32'h0, 1'b0);
    burst(60);
    rw(rmi_pkg::REG_STAT, 32'hffffffff);
    rw(rmi_pkg::REG_CTRL, 32'hfffffffe);
    legacy = 0;
    rr(rmi_pkg::REG_CTRL, 32'h0);
    burst(40);
    rw(rmi_pkg::REG_CTRL, 32'h1);
    legacy = 1;
    burst(20);
    rr(rmi_pkg::REG_STAT, {refCnt[15:0], doneCnt[15:0]});
    rr(rmi_pkg::REG_LAST, lastRes);
    report_and_stop();
  end
endmodule : test_rotate_mask_insert_unit

// >>> verilog/rmi_pkg.sv
// Purpose: Shared constants for the rotate, mask and insert unit
// Assumes: 32-bit words, bit 0 of a word is its most significant bit
// Notes:   Register offsets are byte addresses on the plain register port
package rmi_pkg;

  // ==========================================================
  // Instruction word layout (LSB numbering of the word)
  // ==========================================================
  localparam int unsigned OPC_MSB   = 31;     // Primary opcode field top
  localparam int unsigned OPC_LSB   = 26;     // Primary opcode field bottom
  localparam int unsigned SRC_LSB   = 21;     // source_reg index field
  localparam int unsigned DST_LSB   = 16;     // dest_reg index field
  localparam int unsigned SHR_LSB   = 11;     // shift_amount_reg index field
  localparam int unsigned BEG_LSB   = 6;      // mask_begin field
  localparam int unsigned END_LSB   = 1;      // mask_end field
  localparam int unsigned XO_MSB    = 10;     // Extended opcode field top
  localparam int unsigned XO_LSB    = 1;      // Extended opcode field bottom
  localparam int unsigned REC_BIT   = 0;      // record_flag position

  // ==========================================================
  // Opcode values
  // ==========================================================
  localparam logic [5:0] OPC_ROT_MASK = 6'h17;  // Rotate then AND with mask
  localparam logic [5:0] OPC_EXTENDED = 6'h1f;  // Extended group
  localparam logic [9:0] XO_ROT_INS   = 10'h219; // Rotate right and insert bit

  // ==========================================================
  // Register port map
  // ==========================================================
  localparam logic [3:0] REG_CTRL   = 4'h0;   // bit0 legacy architecture mode
  localparam logic [3:0] REG_STAT   = 4'h4;   // executed / refused counts
  localparam logic [3:0] REG_LAST   = 4'h8;   // last result written
  localparam logic       CTRL_RST   = 1'b1;   // Legacy mode after reset
  localparam int unsigned CNT_W     = 16;     // Width of each counter

  // Condition field 0 bit positions in crField
  localparam int unsigned CR_NEG = 3;
  localparam int unsigned CR_POS = 2;
  localparam int unsigned CR_ZER = 1;
  localparam int unsigned CR_SOV = 0;

endpackage : rmi_pkg

// >>> verilog/rmi_rotate_mask_insert_unit.sv
// Purpose: Rotate-and-mask and rotate-insert-bit execution datapath
// Assumes: Operands arrive with the issue strobe; one result cycle later
// Notes:   Exception register is only read (summary overflow copy)
//
// Summary of operation
// - Rotate source left by shift low bits
// - AND rotation with mask, write destination
// - Begin below end+1: ones begin..end
// - Begin equals end+1: all ones mask
// - Begin above end+1: zeros end+1..begin-1
// - Record flag set updates condition field
// - Never modify the fixed-point exception register
// - Insert source bit 0 at shift position
// - Other destination bits stay unchanged
// - Insert operation only in legacy mode
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/100ps

module rmi_rotate_mask_insert_unit (
  input  wire logic        core_clk,      // 25 MHz core clock
  input  wire logic        nrst,          // Async reset, active low
  input  wire logic        issueValid,    // Instruction issued this cycle
  input  wire logic [31:0] instrWord,     // Instruction word
  input  wire logic [31:0] sourceVal,     // source_reg contents
  input  wire logic [31:0] shiftVal,      // shift_amount_reg contents
  input  wire logic [31:0] destVal,       // Current dest_reg contents
  input  wire logic        xerSumOvf,     // Summary overflow, read only
  input  wire logic [3:0]  regAddr,       // Register port address
  input  wire logic [31:0] regWrData,     // Register port write data
  input  wire logic        regWr,         // Register write strobe
  input  wire logic        regRd,         // Register read strobe
  output logic [31:0]      regRdData,     // Read data, cycle after strobe
  output logic             resultValid,   // Destination write pulse
  output logic [4:0]       resultIdx,     // dest_reg index
  output logic [31:0]      resultData,    // Value to write
  output logic             crWrEn,        // Condition field 0 write pulse
  output logic [3:0]       crField,       // negative,positive,zero,sum_overflow
  output logic             illegalOp      // Unsupported instruction pulse
);

  // ==========================================================
  // Decode helpers
  // ==========================================================
  // Primary opcode of the rotate-and-mask form
  function automatic logic isRotMask(input logic [31:0] w);
    isRotMask = (w[rmi_pkg::OPC_MSB:rmi_pkg::OPC_LSB] == rmi_pkg::OPC_ROT_MASK);
  endfunction : isRotMask

  // Extended opcode of the rotate-insert-bit form
  function automatic logic isRotIns(input logic [31:0] w);
    isRotIns = (w[rmi_pkg::OPC_MSB:rmi_pkg::OPC_LSB] == rmi_pkg::OPC_EXTENDED) &&
               (w[rmi_pkg::XO_MSB:rmi_pkg::XO_LSB] == rmi_pkg::XO_ROT_INS);
  endfunction : isRotIns

  // ==========================================================
  // Field extraction
  // ==========================================================
  logic [4:0]  maskBegin;     // Mask start position
  logic [4:0]  maskEnd;       // Mask end position
  logic [4:0]  rotCount;      // Low five bits of shift operand
  logic        recordFlag;    // Last instruction bit
  logic        opRotMask;     // Rotate-and-mask decoded
  logic        opRotIns;      // Rotate-insert decoded
  logic        legacyMode;    // Control bit, legacy architecture

  assign maskBegin  = instrWord[rmi_pkg::BEG_LSB +: 5];
  assign maskEnd    = instrWord[rmi_pkg::END_LSB +: 5];
  assign recordFlag = instrWord[rmi_pkg::REC_BIT];
  assign rotCount   = shiftVal[4:0];
  assign opRotMask  = isRotMask(instrWord);
  assign opRotIns   = isRotIns(instrWord);

  // ==========================================================
  // Mask generator
  // ==========================================================
  // Six-bit compare so end+1 can reach 32 without wrapping
  logic [5:0]  endPlusOne;    // mask_end + 1
  logic [5:0]  beginWide;     // mask_begin widened
  logic [31:0] genMask;       // Generated mask, LSB numbering

  assign endPlusOne = {1'b0, maskEnd} + 6'h01;
  assign beginWide  = {1'b0, maskBegin};

  generate
    for (genvar p = 0; p < 32; p++) begin : g_mask
      // Position p is big-endian, so it lands on LSB index 31-p
      localparam logic [5:0] POS = 6'(p);
      // One continuous driver per bit keeps the vector single-driven
      assign genMask[31-p] = (beginWide < endPlusOne)  ? ((POS >= beginWide) && (POS < endPlusOne)) :
                             (beginWide == endPlusOne) ? 1'b1 :
                             !((POS >= endPlusOne) && (POS < beginWide));
    end
  endgenerate

  // ==========================================================
  // Datapath
  // ==========================================================
  logic [63:0] rotWide;       // Doubled word shifted left
  logic [31:0] rotWord;       // Rotated source
  logic [31:0] insMask;       // Single targeted position
  logic [31:0] next_result;   // Result selected by opcode
  logic        next_illegal;  // Unsupported in current mode
  logic        next_valid;    // Destination write next cycle

  // Rotate as upper half of a doubled word, no mux tree needed
  assign rotWide = {sourceVal, sourceVal} << rotCount;
  assign rotWord = rotWide[63:32];
  // Bit 0 moved right by n sits at big-endian position n
  assign insMask = 32'h8000_0000 >> rotCount;

  // Operation select and mode check
  always_comb begin
    next_result  = 32'h0000_0000;
    next_illegal = 1'b0;
    next_valid   = 1'b0;
    if (issueValid && opRotMask) begin
      next_result = rotWord & genMask;
      next_valid  = 1'b1;
    end else if (issueValid && opRotIns) begin
      if (legacyMode) begin
        // Only the targeted bit is replaced
        next_result = (destVal & ~insMask) |
                      (sourceVal[31] ? insMask : 32'h0000_0000);
        next_valid  = 1'b1;
      end else begin
        next_illegal = 1'b1;
      end
    end
  end

  // ==========================================================
  // Result registers
  // ==========================================================
  // Destination write port, one pulse per accepted instruction
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      resultValid <= 1'b0;
      resultIdx   <= 5'h00;
      resultData  <= 32'h0000_0000;
      illegalOp   <= 1'b0;
    end else begin
      resultValid <= next_valid;
      illegalOp   <= next_illegal;
      if (next_valid) begin
        resultIdx  <= instrWord[rmi_pkg::DST_LSB +: 5];
        resultData <= next_result;
      end
    end
  end

  // Condition field 0, written only in record form
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      crWrEn  <= 1'b0;
      crField <= 4'h0;
    end else begin
      crWrEn <= next_valid && recordFlag;
      if (next_valid && recordFlag) begin
        crField[rmi_pkg::CR_NEG] <= next_result[31];
        crField[rmi_pkg::CR_POS] <= !next_result[31] && (next_result != 32'h0);
        crField[rmi_pkg::CR_ZER] <= (next_result == 32'h0000_0000);
        // Copied, never written back: exception register untouched
        crField[rmi_pkg::CR_SOV] <= xerSumOvf;
      end
    end
  end

  // ==========================================================
  // Register port
  // ==========================================================
  logic [rmi_pkg::CNT_W-1:0] doneCount;    // Accepted operations
  logic [rmi_pkg::CNT_W-1:0] refuseCount;  // Refused operations

  // Control register: architecture mode steers the insert path
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      legacyMode <= rmi_pkg::CTRL_RST;
    end else if (regWr && regAddr == rmi_pkg::REG_CTRL) begin
      legacyMode <= regWrData[0];
    end
  end

  // Counters wrap silently; software samples differences
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      doneCount   <= '0;
      refuseCount <= '0;
    end else begin
      if (next_valid) begin
        doneCount <= doneCount + 1'b1;
      end
      if (next_illegal) begin
        refuseCount <= refuseCount + 1'b1;
      end
    end
  end

  // Read data holds only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      regRdData <= 32'h0000_0000;
    end else if (regRd) begin
      unique case (regAddr)
        rmi_pkg::REG_CTRL: regRdData <= {31'h0, legacyMode};
        rmi_pkg::REG_STAT: regRdData <= {refuseCount, doneCount};
        rmi_pkg::REG_LAST: regRdData <= resultData;
        default:           regRdData <= 32'h0000_0000;  // Unmapped reads zero
      endcase
    end else begin
      regRdData <= 32'h0000_0000;
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // Issue of each operation kind
  sequence s_rotMask;
    issueValid && opRotMask;
  endsequence
  sequence s_rotIns;
    issueValid && opRotIns && legacyMode;
  endsequence

  property p_rotate;
    (s_rotMask and (maskBegin == 5'h00) and (maskEnd == 5'h1f)) |=>
      resultValid && resultData ==
      32'((({$past(sourceVal), $past(sourceVal)}) << $past(shiftVal[4:0])) >> 32);
  endproperty
  a_rotate: assert property (p_rotate) else $error("rotate value wrong");

  property p_andMask;
    s_rotMask |=> resultValid && ((resultData & ~$past(genMask)) == 32'h0);
  endproperty
  a_andMask: assert property (p_andMask) else $error("bits outside mask set");

  property p_maskRun;
    (maskBegin <= maskEnd) |->
      $countones(genMask) == 32'(maskEnd) - 32'(maskBegin) + 1 && genMask[31 - maskBegin];
  endproperty
  a_maskRun: assert property (p_maskRun) else $error("ones run wrong");

  property p_maskFull;
    (beginWide == endPlusOne) |-> genMask == 32'hffff_ffff;
  endproperty
  a_maskFull: assert property (p_maskFull) else $error("mask not full");

  property p_maskHole;
    (beginWide > endPlusOne) |->
      $countones(genMask) == 33 - (32'(maskBegin) - 32'(maskEnd)) && !genMask[32 - maskBegin];
  endproperty
  a_maskHole: assert property (p_maskHole) else $error("zero gap wrong");

  property p_record;
    crWrEn |-> resultValid && crField[rmi_pkg::CR_ZER] == (resultData == 32'h0) &&
               crField[rmi_pkg::CR_NEG] == resultData[31] && crField[rmi_pkg::CR_SOV] == $past(xerSumOvf);
  endproperty
  a_record: assert property (p_record) else $error("condition field wrong");

  property p_noRecord;
    (issueValid && !recordFlag) |=> !crWrEn && $stable(crField);
  endproperty
  a_noRecord: assert property (p_noRecord) else $error("condition field touched");

  property p_insertBit;
    s_rotIns |=> resultValid && resultData[31 - $past(shiftVal[4:0])] == $past(sourceVal[31]);
  endproperty
  a_insertBit: assert property (p_insertBit) else $error("inserted bit wrong");

  property p_keepOthers;
    s_rotIns |=> ((resultData ^ $past(destVal)) & ~(32'h8000_0000 >> $past(shiftVal[4:0]))) == 32'h0;
  endproperty
  a_keepOthers: assert property (p_keepOthers) else $error("other bits changed");

  // Second step allows a refused insert issued back to back
  property p_newMode;
    (issueValid && opRotIns && !legacyMode) |=> illegalOp && !resultValid ##1
      (illegalOp == $past(issueValid && opRotIns && !legacyMode));
  endproperty
  a_newMode: assert property (p_newMode) else $error("insert not refused");

  // Positive flag only for a nonzero result with sign clear
  property p_positive;
    crWrEn |-> crField[rmi_pkg::CR_POS] == (!resultData[31] && (resultData != 32'h0));
  endproperty
  a_positive: assert property (p_positive) else $error("positive flag wrong");

  property p_recordPulse;
    (issueValid && recordFlag && (opRotMask || (opRotIns && legacyMode))) |=> crWrEn;
  endproperty
  a_recordPulse: assert property (p_recordPulse) else $error("record write missing");

  property p_insertTaken;
    s_rotIns |=> resultValid && !illegalOp;
  endproperty
  a_insertTaken: assert property (p_insertTaken) else $error("legacy insert refused");

  property p_modeWrite;
    (regWr && regAddr == rmi_pkg::REG_CTRL) |=> legacyMode == $past(regWrData[0]);
  endproperty
  a_modeWrite: assert property (p_modeWrite) else $error("mode bit not written");

  property p_destIndex;
    s_rotMask |=> resultIdx == $past(instrWord[rmi_pkg::DST_LSB +: 5]);
  endproperty
  a_destIndex: assert property (p_destIndex) else $error("destination index wrong");

endmodule : rmi_rotate_mask_insert_unit
